// >>> verilog/dts_regs.svh
// offsets, reset values and sizes of the timing and scrub config bank
`ifndef DTS_REGS_SVH
`define DTS_REGS_SVH

// ****************************************************************
// sizes
// ****************************************************************
`define DTS_NREG 24
`define DTS_RANKS 4
`define DTS_BANKS 8
`define DTS_TW 10
`define DTS_REFI_MUL 3

// ****************************************************************
// byte offsets
// ****************************************************************
`define DTS_OFF_CH4_CTRL 12'h1b0
`define DTS_OFF_CH4_LO 12'h1b4
`define DTS_OFF_CH4_HI 12'h1b8
`define DTS_OFF_CH5_CTRL 12'h1c0
`define DTS_OFF_CH5_LO 12'h1c4
`define DTS_OFF_CH5_HI 12'h1c8
`define DTS_OFF_CH6_CTRL 12'h1d0
`define DTS_OFF_CH6_LO 12'h1d4
`define DTS_OFF_CH6_HI 12'h1d8
`define DTS_OFF_CH7_CTRL 12'h1e0
`define DTS_OFF_CH7_LO 12'h1e4
`define DTS_OFF_CH7_HI 12'h1e8
`define DTS_OFF_OPT 12'h1f0
`define DTS_OFF_PATH 12'h1f4
`define DTS_OFF_RMAP 12'h1f8
`define DTS_OFF_SGLB 12'h1fc
`define DTS_OFF_REFI 12'h200
`define DTS_OFF_RFC 12'h204
`define DTS_OFF_MRR 12'h208
`define DTS_OFF_MRW 12'h20c
`define DTS_OFF_RDPD 12'h210
`define DTS_OFF_RCD 12'h218
`define DTS_OFF_RAS 12'h21c
`define DTS_OFF_RP 12'h220
`define DTS_OFF_STAT 12'h2fc

// ****************************************************************
// reset values
// ****************************************************************
`define DTS_RST_SCTRL 32'h1f000000
`define DTS_RST_SBND 32'h00000000
`define DTS_RST_OPT 32'h0aa00000
`define DTS_RST_PATH 32'h00000000
`define DTS_RST_RMAP 32'h76543210
`define DTS_RST_SGLB 32'h00001f00
`define DTS_RST_REFI 32'h00090100
`define DTS_RST_RFC 32'h00008c23
`define DTS_RST_MRR 32'h00000002
`define DTS_RST_MRW 32'h0000000c
`define DTS_RST_RDPD 32'h0000000a
`define DTS_RST_RCD 32'h00000005
`define DTS_RST_RAS 32'h0000000e
`define DTS_RST_RP 32'h00000005

// ****************************************************************
// register indices
// ****************************************************************
`define DTS_I_CH4_CTRL 0
`define DTS_I_RMAP 14
`define DTS_I_REFI 16
`define DTS_I_RFC 17
`define DTS_I_MRR 18
`define DTS_I_MRW 19
`define DTS_I_RDPD 20
`define DTS_I_RCD 21
`define DTS_I_RAS 22
`define DTS_I_RP 23

`endif

// >>> verilog/dts_pkg.sv
// types shared by the timing and scrub config bank
package dts_pkg;
`include "dts_regs.svh"

typedef enum logic [3:0] {
    CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE,
    CMD_REF, CMD_MRR, CMD_MRW, CMD_PDE
} dts_op_e;

typedef struct packed {
    logic valid;
    dts_op_e op;
    logic [2:0] rank;
    logic [2:0] bank;
} dts_cmd_s;

typedef struct packed {
    logic wr;
    logic rd;
    logic [11:0] addr;
    logic [31:0] wdata;
} dts_bus_s;

typedef logic [`DTS_TW-1:0] dts_cnt_t;

typedef struct packed {
    logic [`DTS_NREG-1:0][31:0] regs;
    logic [31:0] rdata;
    dts_cmd_s cmd_out;
    logic taken;
    logic [`DTS_RANKS-1:0][`DTS_TW-1:0] rank_cnt;
    logic [`DTS_RANKS-1:0][`DTS_TW-1:0] pd_cnt;
    logic [`DTS_RANKS*`DTS_BANKS-1:0][`DTS_TW-1:0] rcd_cnt;
    logic [`DTS_RANKS*`DTS_BANKS-1:0][`DTS_TW-1:0] ras_cnt;
    logic [`DTS_RANKS*`DTS_BANKS-1:0][`DTS_TW-1:0] rp_cnt;
    logic [18:0] refi_cnt;
    logic ref_pend;
    logic [1:0] ref_rank;
    logic [15:0] issue_cnt;
} dts_state_s;

endpackage : dts_pkg

// >>> verilog/dts_cfg_timing.sv
// config register bank with dram command spacing enforcement
`timescale 1ns/10ps
// Function
// - after refresh, no command to that rank for refresh cycle time
// - after mode read, no command to that rank for mode read gap
// - after mode write, no command to that rank for mode write gap
// - after read, no power-down to that rank for read-to-powerdown gap
// - after activate, no read or write to that bank for column gap
// - after activate, no precharge to that bank before row active time
// - after precharge, no command to that bank for row precharge time
// - all registers here except the status word read and write in every operating state
// - scrub channel control resets to default, bounds reset to zero
// - global scrub control resets to default, always read-write
// - rank mapping resets to ascending nibbles zero to seven
// - option enables reset to default, path select resets to zero
// - refresh interval resets to default; all registers are 32 bits
module dts_cfg_timing (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // register port
    input wire dts_pkg::dts_bus_s bus,
    output logic [31:0] rdata,
    // command request from the scheduler
    input wire dts_pkg::dts_cmd_s req,
    output logic req_taken,
    // command toward the phy
    output dts_pkg::dts_cmd_s dfi_cmd
);
    import dts_pkg::*;

    // ****************************************************************
    // register map tables
    // ****************************************************************
    localparam logic [11:0] OFFS [`DTS_NREG] = '{
        `DTS_OFF_CH4_CTRL, `DTS_OFF_CH4_LO, `DTS_OFF_CH4_HI,
        `DTS_OFF_CH5_CTRL, `DTS_OFF_CH5_LO, `DTS_OFF_CH5_HI,
        `DTS_OFF_CH6_CTRL, `DTS_OFF_CH6_LO, `DTS_OFF_CH6_HI,
        `DTS_OFF_CH7_CTRL, `DTS_OFF_CH7_LO, `DTS_OFF_CH7_HI,
        `DTS_OFF_OPT, `DTS_OFF_PATH, `DTS_OFF_RMAP, `DTS_OFF_SGLB,
        `DTS_OFF_REFI, `DTS_OFF_RFC, `DTS_OFF_MRR, `DTS_OFF_MRW,
        `DTS_OFF_RDPD, `DTS_OFF_RCD, `DTS_OFF_RAS, `DTS_OFF_RP
    };

    localparam logic [31:0] RSTV [`DTS_NREG] = '{
        `DTS_RST_SCTRL, `DTS_RST_SBND, `DTS_RST_SBND,
        `DTS_RST_SCTRL, `DTS_RST_SBND, `DTS_RST_SBND,
        `DTS_RST_SCTRL, `DTS_RST_SBND, `DTS_RST_SBND,
        `DTS_RST_SCTRL, `DTS_RST_SBND, `DTS_RST_SBND,
        `DTS_RST_OPT, `DTS_RST_PATH, `DTS_RST_RMAP, `DTS_RST_SGLB,
        `DTS_RST_REFI, `DTS_RST_RFC, `DTS_RST_MRR, `DTS_RST_MRW,
        `DTS_RST_RDPD, `DTS_RST_RCD, `DTS_RST_RAS, `DTS_RST_RP
    };

    // ****************************************************************
    // helpers
    // ****************************************************************
    // returns {hit, index}
    function automatic logic [5:0] dec(logic [11:0] a);
        logic [5:0] r;
        r = 6'h0;
        for (int i = 0; i < `DTS_NREG; i++) begin
            if (a == OFFS[i]) begin
                r = {1'b1, 5'(i)};
            end
        end
        return r;
    endfunction : dec

    // counter load; the issue cycle itself counts as one
    function automatic dts_cnt_t ld(logic [31:0] v);
        return (v[`DTS_TW-1:0] == '0) ? '0 : v[`DTS_TW-1:0] - 10'h1;
    endfunction : ld

    function automatic logic [1:0] remap(logic [31:0] m, logic [2:0] r);
        return m[{r, 2'b00} +: 2];
    endfunction : remap

    function automatic logic is_rw(dts_op_e op);
        return (op == CMD_RD) || (op == CMD_WR);
    endfunction : is_rw

    dts_state_s q;
    dts_state_s n;

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        logic [5:0] d;
        logic [1:0] pr;
        logic [4:0] bi;
        logic [4:0] ib;
        logic ok;
        dts_cmd_s iss;
        n = q;
        d = dec(bus.addr);
        pr = remap(q.regs[`DTS_I_RMAP], req.rank);
        bi = {pr, req.bank};
        ib = 5'h0;
        ok = 1'b0;
        iss = '0;
        n.taken = 1'b0;
        n.rdata = 32'h0;

        // no state gating on any access
        if (bus.wr && d[5]) begin
            n.regs[d[4:0]] = bus.wdata;
        end
        if (bus.rd) begin
            if (d[5]) begin
                n.rdata = q.regs[d[4:0]];
            end else if (bus.addr == `DTS_OFF_STAT) begin
                n.rdata = {15'h0, q.ref_pend, q.issue_cnt};
            end
        end

        // all spacing counters run down to zero
        for (int r = 0; r < `DTS_RANKS; r++) begin
            if (q.rank_cnt[r] != '0) begin
                n.rank_cnt[r] = q.rank_cnt[r] - 10'h1;
            end
            if (q.pd_cnt[r] != '0) begin
                n.pd_cnt[r] = q.pd_cnt[r] - 10'h1;
            end
        end
        for (int b = 0; b < `DTS_RANKS * `DTS_BANKS; b++) begin
            if (q.rcd_cnt[b] != '0) begin
                n.rcd_cnt[b] = q.rcd_cnt[b] - 10'h1;
            end
            if (q.ras_cnt[b] != '0) begin
                n.ras_cnt[b] = q.ras_cnt[b] - 10'h1;
            end
            if (q.rp_cnt[b] != '0) begin
                n.rp_cnt[b] = q.rp_cnt[b] - 10'h1;
            end
        end

        // ************************************************************
        // arbitration: refresh first, then the scheduler
        // ************************************************************
        ok = q.ref_pend && (q.rank_cnt[q.ref_rank] == '0);
        for (int b = 0; b < `DTS_BANKS; b++) begin
            if (q.rp_cnt[{q.ref_rank, 3'(b)}] != '0) begin
                ok = 1'b0;
            end
        end
        if (ok) begin
            iss.valid = 1'b1;
            iss.op = CMD_REF;
            iss.rank = {1'b0, q.ref_rank};
            n.ref_pend = 1'b0;
            n.ref_rank = q.ref_rank + 2'h1;
        end else if (req.valid && !q.taken
                     && q.rank_cnt[pr] == '0
                     && q.rp_cnt[bi] == '0
                     && !(is_rw(req.op) && q.rcd_cnt[bi] != '0)
                     && !(req.op == CMD_PRE && q.ras_cnt[bi] != '0)
                     && !(req.op == CMD_PDE && q.pd_cnt[pr] != '0)) begin
            iss = req;
            iss.rank = {1'b0, pr};
            n.taken = 1'b1;
        end

        // ************************************************************
        // load spacing counters from the timing registers
        // ************************************************************
        ib = {iss.rank[1:0], iss.bank};
        if (iss.valid) begin
            n.issue_cnt = q.issue_cnt + 16'h1;
            case (iss.op)
                CMD_REF: begin
                    n.rank_cnt[iss.rank[1:0]] = ld(q.regs[`DTS_I_RFC]);
                end
                CMD_MRR: begin
                    n.rank_cnt[iss.rank[1:0]] = ld(q.regs[`DTS_I_MRR]);
                end
                CMD_MRW: begin
                    n.rank_cnt[iss.rank[1:0]] = ld(q.regs[`DTS_I_MRW]);
                end
                CMD_RD: begin
                    n.pd_cnt[iss.rank[1:0]] = ld(q.regs[`DTS_I_RDPD]);
                end
                CMD_ACT: begin
                    n.rcd_cnt[ib] = ld(q.regs[`DTS_I_RCD]);
                    n.ras_cnt[ib] = ld(q.regs[`DTS_I_RAS]);
                end
                CMD_PRE: begin
                    n.rp_cnt[ib] = ld(q.regs[`DTS_I_RP]);
                end
                default: begin
                end
            endcase
        end
        n.cmd_out = iss;

        // refresh pacing; placed last so a new request beats the clear
        if (q.refi_cnt == 19'h0) begin
            n.refi_cnt = {q.regs[`DTS_I_REFI][15:0], 3'b000} - 19'h1;
            n.ref_pend = 1'b1;
        end else begin
            n.refi_cnt = q.refi_cnt - 19'h1;
        end
    end

    // ****************************************************************
    // state register
    // ****************************************************************
    always_ff @(posedge mclk) begin
        if (rst) begin
            q <= '0;
            for (int i = 0; i < `DTS_NREG; i++) begin
                q.regs[i] <= RSTV[i];
            end
        end else begin
            q <= n;
        end
    end

    assign rdata = q.rdata;
    assign req_taken = q.taken;
    assign dfi_cmd = q.cmd_out;

    // ****************************************************************
    // checks
    // ****************************************************************
    property p_rfc;
        @(posedge mclk) disable iff (rst)
        q.cmd_out.valid && q.cmd_out.op == CMD_REF
        |-> q.rank_cnt[q.cmd_out.rank[1:0]]
            == ld($past(q.regs[`DTS_I_RFC]));
    endproperty
    a_rfc: assert property (p_rfc) else $error("refresh gap");

    property p_mrr;
        @(posedge mclk) disable iff (rst)
        q.cmd_out.valid && q.cmd_out.op == CMD_MRR
        |-> q.rank_cnt[q.cmd_out.rank[1:0]]
            == ld($past(q.regs[`DTS_I_MRR]));
    endproperty
    a_mrr: assert property (p_mrr) else $error("mode read gap");

    property p_mrw;
        @(posedge mclk) disable iff (rst)
        q.cmd_out.valid && q.cmd_out.op == CMD_MRW
        |-> q.rank_cnt[q.cmd_out.rank[1:0]]
            == ld($past(q.regs[`DTS_I_MRW]));
    endproperty
    a_mrw: assert property (p_mrw) else $error("mode write gap");

    property p_rdpd;
        @(posedge mclk) disable iff (rst)
        q.cmd_out.valid && q.cmd_out.op == CMD_RD
        |-> q.pd_cnt[q.cmd_out.rank[1:0]]
            == ld($past(q.regs[`DTS_I_RDPD]));
    endproperty
    a_rdpd: assert property (p_rdpd) else $error("read pd gap");

    property p_act;
        @(posedge mclk) disable iff (rst)
        q.cmd_out.valid && q.cmd_out.op == CMD_ACT
        |-> q.rcd_cnt[{q.cmd_out.rank[1:0], q.cmd_out.bank}]
            == ld($past(q.regs[`DTS_I_RCD]));
    endproperty
    a_act: assert property (p_act) else $error("column gap");

    // a precharge only leaves once the row active count has run out
    property p_ras;
        @(posedge mclk) disable iff (rst)
        q.cmd_out.valid && q.cmd_out.op == CMD_PRE
        |-> q.ras_cnt[{q.cmd_out.rank[1:0], q.cmd_out.bank}] == '0;
    endproperty
    a_ras: assert property (p_ras) else $error("row active");

    property p_rp;
        @(posedge mclk) disable iff (rst)
        q.cmd_out.valid && q.cmd_out.op == CMD_PRE
        |-> q.rp_cnt[{q.cmd_out.rank[1:0], q.cmd_out.bank}]
            == ld($past(q.regs[`DTS_I_RP]));
    endproperty
    a_rp: assert property (p_rp) else $error("precharge gap");

    property p_rst_map;
        @(posedge mclk) disable iff (rst)
        $fell(rst) |-> q.regs[`DTS_I_RMAP] == `DTS_RST_RMAP
            && q.regs[`DTS_I_CH4_CTRL] == `DTS_RST_SCTRL;
    endproperty
    a_rst_map: assert property (p_rst_map) else $error("reset map");

    property p_rst_refi;
        @(posedge mclk) disable iff (rst)
        $fell(rst) |-> q.regs[`DTS_I_REFI] == `DTS_RST_REFI
            && q.regs[`DTS_I_RFC] == `DTS_RST_RFC;
    endproperty
    a_rst_refi: assert property (p_rst_refi) else $error("reset refi");

    // gate checks: at issue the target counter must already read zero
    property p_rcd_gate;
        @(posedge mclk) disable iff (rst)
        q.cmd_out.valid && is_rw(q.cmd_out.op)
        |-> q.rcd_cnt[{q.cmd_out.rank[1:0], q.cmd_out.bank}] == '0;
    endproperty
    a_rcd_gate: assert property (p_rcd_gate) else $error("col");

    property p_rp_gate;
        @(posedge mclk) disable iff (rst)
        q.cmd_out.valid && q.cmd_out.op != CMD_PRE
        |-> q.rp_cnt[{q.cmd_out.rank[1:0], q.cmd_out.bank}] == '0;
    endproperty
    a_rp_gate: assert property (p_rp_gate) else $error("bank");

    property p_rank_gate;
        @(posedge mclk) disable iff (rst)
        q.cmd_out.valid && q.cmd_out.op != CMD_REF
        && q.cmd_out.op != CMD_MRR && q.cmd_out.op != CMD_MRW
        |-> q.rank_cnt[q.cmd_out.rank[1:0]] == '0;
    endproperty
    a_rank_gate: assert property (p_rank_gate) else $error("rank");

    property p_pd_gate;
        @(posedge mclk) disable iff (rst)
        q.cmd_out.valid && q.cmd_out.op == CMD_PDE
        |-> q.pd_cnt[q.cmd_out.rank[1:0]] == '0;
    endproperty
    a_pd_gate: assert property (p_pd_gate) else $error("pd");

    // the issued rank is the one the mapping held when it was taken
    property p_rank_pair;
        @(posedge mclk) disable iff (rst)
        q.taken
        |-> q.cmd_out.rank
            == {1'b0, remap($past(q.regs[`DTS_I_RMAP]), $past(req.rank))}
            && q.cmd_out.bank == $past(req.bank);
    endproperty
    a_rank_pair: assert property (p_rank_pair) else $error("remap");

    property p_rmap;
        @(posedge mclk) disable iff (rst)
        q.cmd_out.valid |-> !q.cmd_out.rank[2];
    endproperty
    a_rmap: assert property (p_rmap) else $error("phys rank");

    property p_rdata_idle;
        @(posedge mclk) disable iff (rst)
        !$past(bus.rd) |-> q.rdata == 32'h0;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("rdata");

    // live decode of the bus address, for the write check
    logic [5:0] bus_dec;
    assign bus_dec = dec(bus.addr);

    property p_wr_lands;
        @(posedge mclk) disable iff (rst)
        bus.wr && bus_dec[5]
        |=> q.regs[$past(bus_dec[4:0])] == $past(bus.wdata);
    endproperty
    a_wr_lands: assert property (p_wr_lands) else $error("write");

    // the tick must win over a refresh clearing the pending flag
    property p_refi_tick;
        @(posedge mclk) disable iff (rst)
        q.refi_cnt == 19'h0 |=> q.ref_pend;
    endproperty
    a_refi_tick: assert property (p_refi_tick) else $error("tick");

    property p_issue_cnt;
        @(posedge mclk) disable iff (rst)
        q.cmd_out.valid |-> q.issue_cnt == $past(q.issue_cnt) + 16'h1;
    endproperty
    a_issue_cnt: assert property (p_issue_cnt) else $error("count");

    property p_rst_out;
        @(posedge mclk) disable iff (rst)
        $fell(rst) |-> q.rdata == 32'h0 && !q.taken && !q.cmd_out.valid;
    endproperty
    a_rst_out: assert property (p_rst_out) else $error("reset out");

endmodule : dts_cfg_timing

// >>> tb/dts_dram_model.sv
// behavioural dram rank model watching the phy command port
`timescale 1ns/10ps
module dts_dram_model (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // command from the controller
    input wire dts_pkg::dts_cmd_s dfi_cmd,
    // observation for the bench
    output int ref_t,
    output int n_cmd
);
    import dts_pkg::*;
    // free-running so its count matches the bench cycle count
    int cyc = 0;
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (rst) begin
            ref_t <= -1;
            n_cmd <= 0;
        end else if (dfi_cmd.valid === 1'b1) begin
            n_cmd <= n_cmd + 1;
            if (dfi_cmd.op == CMD_REF) begin
                // rank busy from here for the refresh cycle time
                ref_t <= cyc;
            end
        end
    end
endmodule : dts_dram_model

// >>> tb/dram_timing_scrub_config_bench.sv
// bench for the timing and scrub config bank
`timescale 1ns/10ps
`include "dts_regs.svh"
module dram_timing_scrub_config_bench;
    import dts_pkg::*;
    logic mclk;
    logic rst;
    dts_bus_s bus;
    dts_cmd_s req;
    logic [31:0] rdata;
    logic req_taken;
    dts_cmd_s dfi_cmd;
    int bad_count = 0;
    int n_tests = 0;
    int cyc = 0;
    int ref_t;
    int n_cmd;
    int t0;
    int t1;
    logic [11:0] offs [24] = '{`DTS_OFF_CH4_CTRL, `DTS_OFF_CH4_LO,
        `DTS_OFF_CH4_HI, `DTS_OFF_CH5_CTRL, `DTS_OFF_CH5_LO, `DTS_OFF_CH5_HI,
        `DTS_OFF_CH6_CTRL, `DTS_OFF_CH6_LO, `DTS_OFF_CH6_HI,
        `DTS_OFF_CH7_CTRL, `DTS_OFF_CH7_LO, `DTS_OFF_CH7_HI, `DTS_OFF_OPT,
        `DTS_OFF_PATH, `DTS_OFF_RMAP, `DTS_OFF_SGLB, `DTS_OFF_REFI,
        `DTS_OFF_RFC, `DTS_OFF_MRR, `DTS_OFF_MRW, `DTS_OFF_RDPD,
        `DTS_OFF_RCD, `DTS_OFF_RAS, `DTS_OFF_RP};
    logic [31:0] rsts [24] = '{`DTS_RST_SCTRL, `DTS_RST_SBND, `DTS_RST_SBND,
        `DTS_RST_SCTRL, `DTS_RST_SBND, `DTS_RST_SBND, `DTS_RST_SCTRL,
        `DTS_RST_SBND, `DTS_RST_SBND, `DTS_RST_SCTRL, `DTS_RST_SBND,
        `DTS_RST_SBND, `DTS_RST_OPT, `DTS_RST_PATH, `DTS_RST_RMAP,
        `DTS_RST_SGLB, `DTS_RST_REFI, `DTS_RST_RFC, `DTS_RST_MRR,
        `DTS_RST_MRW, `DTS_RST_RDPD, `DTS_RST_RCD, `DTS_RST_RAS, `DTS_RST_RP};

    dts_cfg_timing dut (.mclk(mclk), .rst(rst), .bus(bus), .rdata(rdata),
        .req(req), .req_taken(req_taken), .dfi_cmd(dfi_cmd));
    dts_dram_model phy (.mclk(mclk), .rst(rst), .dfi_cmd(dfi_cmd),
        .ref_t(ref_t), .n_cmd(n_cmd));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    always @(posedge mclk) cyc <= cyc + 1;

    // ****************************************************************
    // helpers
    // ****************************************************************
    task summarize;
        if (bad_count == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : summarize

    task check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            $display("BAD %0t got %h want %h", $time, got, exp);
            bad_count++;
        end
    endtask : check

    // one idle cycle after each strobe keeps each driver step single
    task wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk) bus <= '{1'b1, 1'b0, a, d};
        @(posedge mclk) bus <= '0;
    endtask : wr

    task rd(input logic [11:0] a, input logic [31:0] exp);
        @(posedge mclk) bus <= '{1'b0, 1'b1, a, 32'h0};
        @(posedge mclk) bus <= '0;
        @(negedge mclk) check(rdata, exp);
    endtask : rd

    // req is left valid; the block ignores it during the taken cycle
    task send(input dts_op_e op, input logic [2:0] rk, input logic [2:0] bk,
              input logic [2:0] prk, output int t);
        int n;
        n = 0;
        @(posedge mclk) req <= '{1'b1, op, rk, bk};
        do begin
            @(negedge mclk);
            n++;
        end while (req_taken !== 1'b1 && n < 300);
        t = cyc;
        check(req_taken, 1'b1);
        check({21'h0, dfi_cmd}, {21'h0, 1'b1, op, prk, bk});
    endtask : send

    task idle;
        @(posedge mclk) req.valid <= 1'b0;
    endtask : idle

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task s_refresh;
        send(CMD_ACT, 3'h0, 3'h0, 3'h0, t0);
        check(t0 - ref_t, 32'd35);
        idle();
        // the new period only loads at the next tick; the first 2048-cycle interval keeps later gaps free of refresh stalls
        wr(`DTS_OFF_REFI, 32'h0000ffff);
    endtask : s_refresh

    task s_bank;
        send(CMD_RD, 3'h0, 3'h0, 3'h0, t1);
        check(t1 - t0, 32'd5);
        send(CMD_PRE, 3'h0, 3'h0, 3'h0, t1);
        check(t1 - t0, 32'd14);
        send(CMD_ACT, 3'h0, 3'h0, 3'h0, t0);
        check(t0 - t1, 32'd5);
        send(CMD_RD, 3'h0, 3'h0, 3'h0, t1);
        send(CMD_PDE, 3'h0, 3'h0, 3'h0, t0);
        check(t0 - t1, 32'd10);
        idle();
        wr(`DTS_OFF_RCD, 32'h00000008);
        send(CMD_ACT, 3'h2, 3'h1, 3'h2, t0);
        send(CMD_WR, 3'h2, 3'h1, 3'h2, t1);
        check(t1 - t0, 32'd8);
        idle();
    endtask : s_bank

    task s_mode;
        send(CMD_MRW, 3'h1, 3'h0, 3'h1, t0);
        send(CMD_ACT, 3'h1, 3'h0, 3'h1, t1);
        check(t1 - t0, 32'd12);
        idle();
        wr(`DTS_OFF_MRR, 32'h00000006);
        send(CMD_MRR, 3'h1, 3'h0, 3'h1, t0);
        send(CMD_ACT, 3'h1, 3'h3, 3'h1, t1);
        check(t1 - t0, 32'd6);
        idle();
    endtask : s_mode

    task s_remap;
        wr(`DTS_OFF_RMAP, 32'h76543213);
        rd(`DTS_OFF_RMAP, 32'h76543213);
        send(CMD_ACT, 3'h0, 3'h2, 3'h3, t0);
        idle();
    endtask : s_remap

    task s_regs;
        @(posedge mclk) rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        for (int i = 0; i < 24; i++) begin
            rd(offs[i], rsts[i]);
        end
        for (int i = 0; i < 24; i++) begin
            wr(offs[i], ~rsts[i]);
            rd(offs[i], ~rsts[i]);
        end
        // unmapped place: write dropped, read gives zero
        wr(12'h214, 32'hffffffff);
        rd(12'h214, 32'h0);
        // only the refresh right after the reset has issued since
        rd(`DTS_OFF_STAT, 32'h00000001);
    endtask : s_regs

    initial begin
        rst = 1'b1;
        bus = '0;
        req = '0;
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        s_refresh();
        s_bank();
        s_mode();
        s_remap();
        s_regs();
        check(n_cmd, 32'd1);
        summarize();
    end

    initial begin
        #100000;
        bad_count++;
        summarize();
    end
endmodule : dram_timing_scrub_config_bench
